// [src/button_sense_port.sv]
// Behaviour
// - Acknowledge accesses to critical registers within 140 us in normal operation.
// - Acknowledge the store-to-flash command within 100 us.
// - After a save, refuse all access until flash write completes; host waits.
// - Optional averaging filter over 2, 4, 8 or 16 raw samples.
// - Drop-sample filter discards a sample if bus traffic hit its scan.
// - Four PWM configuration registers at offsets 18h to 1Bh.
// - PWM offers fifteen selectable duty cycles.
// - PWM modes: normal, single pulse, delayed transition, toggle flip-flop.
// - Save fails when the sleep interval is 512 Hz or 64 Hz.
module button_sense_port
  import button_sense_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h37
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // serial port pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // sensing core
  input wire logic scan_start,
  input wire logic sample_valid,
  input wire logic [SAMPLE_W-1:0] raw_count,
  output logic [SAMPLE_W-1:0] filt_count,
  output logic filt_valid,
  // led dimming
  input wire logic pwm_trigger,
  output logic pwm_out,
  // non-volatile store
  input wire logic [1:0] sleep_interval,
  input wire logic flash_done,
  output logic flash_save_req,
  output logic save_busy,
  output logic save_failed
);

  // pin synchronisers and edge detection
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_d;
  logic sda_d;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else if (ce)
    begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_d <= scl_sync[1];
      sda_d <= sda_sync[1];
    end
  end

  wire scl_s = scl_sync[1];
  wire sda_s = sda_sync[1];
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det = scl_s & scl_d & ~sda_d & sda_s;

  // boot delay: the port stays deaf until the core is up
  logic [9:0] boot_cnt;
  logic booted;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      boot_cnt <= 10'h000;
      booted <= 1'b0;
    end
    else if (ce && !booted)
    begin
      boot_cnt <= boot_cnt + 10'h001;
      booted <= (boot_cnt == BOOT_CYCLES);
    end
  end

  // serial slave
  i2c_state_type state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] txsh;
  logic [7:0] ptr;
  logic ptr_pending;
  logic rw;
  logic master_nack;
  reg_write_type wr;
  logic [7:0] rd_data;

  wire addr_hit = (shreg[7:1] == DEV_ADDR) && !save_busy;
  wire byte_done = (bit_cnt == 4'h8);

  assign sda_out = 1'b0;

  // ack goes out on the scl fall that ends the byte, a few clocks after
  // the pin edge, far inside either latency bound
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= st_idle;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      txsh <= 8'h00;
      ptr <= 8'h00;
      ptr_pending <= 1'b0;
      rw <= 1'b0;
      master_nack <= 1'b0;
      sda_oe <= 1'b0;
      wr <= '0;
    end
    else if (ce)
    begin
      wr.en <= 1'b0;
      if (stop_det || !booted)
      begin
        state <= st_idle;
        sda_oe <= 1'b0;
      end
      else if (start_det)
      begin
        state <= st_addr;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
        ptr_pending <= 1'b1;
      end
      else if (scl_rise)
      begin
        case (state)
          st_addr, st_rx:
          begin
            shreg <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end
          st_tx: bit_cnt <= bit_cnt + 4'h1;
          st_tx_ack: master_nack <= sda_s;
          default: ;
        endcase
      end
      else if (scl_fall)
      begin
        case (state)
          st_addr:
          begin
            if (byte_done)
            begin
              // busy saving: address is not acknowledged
              if (addr_hit)
              begin
                sda_oe <= 1'b1;
                rw <= shreg[0];
                state <= st_addr_ack;
              end
              else
              begin
                state <= st_idle;
              end
            end
          end
          st_addr_ack:
          begin
            bit_cnt <= 4'h0;
            if (rw)
            begin
              txsh <= rd_data;
              sda_oe <= ~rd_data[7];
              state <= st_tx;
            end
            else
            begin
              sda_oe <= 1'b0;
              state <= st_rx;
            end
          end
          st_rx:
          begin
            if (byte_done)
            begin
              if (save_busy)
              begin
                sda_oe <= 1'b0;
                state <= st_idle;
              end
              else
              begin
                sda_oe <= 1'b1;
                state <= st_rx_ack;
                if (ptr_pending)
                begin
                  ptr <= shreg;
                  ptr_pending <= 1'b0;
                end
                else
                begin
                  wr <= '{en: 1'b1, addr: ptr, data: shreg};
                  ptr <= ptr + 8'h01;
                end
              end
            end
          end
          st_rx_ack:
          begin
            sda_oe <= 1'b0;
            bit_cnt <= 4'h0;
            state <= st_rx;
          end
          st_tx:
          begin
            if (byte_done)
            begin
              sda_oe <= 1'b0;
              state <= st_tx_ack;
              ptr <= ptr + 8'h01;
            end
            else
            begin
              txsh <= {txsh[6:0], 1'b0};
              sda_oe <= ~txsh[6];
            end
          end
          st_tx_ack:
          begin
            if (master_nack)
            begin
              state <= st_idle;
            end
            else
            begin
              txsh <= rd_data;
              sda_oe <= ~rd_data[7];
              bit_cnt <= 4'h0;
              state <= st_tx;
            end
          end
          default: state <= st_idle;
        endcase
      end
    end
  end

  // register file
  logic [7:0] pwm_a;
  logic [7:0] pwm_b;
  logic [7:0] pwm_c;
  logic [7:0] pwm_d;
  logic [7:0] filter_cfg;

  wire wr_pwm_a = wr.en && (wr.addr == OFF_PWM_A);
  wire wr_pwm_b = wr.en && (wr.addr == OFF_PWM_B);
  wire wr_pwm_c = wr.en && (wr.addr == OFF_PWM_C);
  wire wr_pwm_d = wr.en && (wr.addr == OFF_PWM_D);
  wire wr_filter = wr.en && (wr.addr == OFF_FILTER);
  wire cmd_save = wr.en && (wr.addr == OFF_COMMAND) && (wr.data == CMD_SAVE);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pwm_a <= PWM_RESET;
      pwm_b <= PWM_RESET;
      pwm_c <= PWM_RESET;
      pwm_d <= PWM_RESET;
      filter_cfg <= FILTER_RESET;
    end
    else if (ce)
    begin
      if (wr_pwm_a) pwm_a <= wr.data;
      if (wr_pwm_b) pwm_b <= wr.data;
      if (wr_pwm_c) pwm_c <= wr.data;
      if (wr_pwm_d) pwm_d <= wr.data;
      if (wr_filter) filter_cfg <= wr.data;
    end
  end

  wire [7:0] status = {5'h00, booted, save_failed, save_busy};

  assign rd_data = (ptr == OFF_PWM_A) ? pwm_a :
                   (ptr == OFF_PWM_B) ? pwm_b :
                   (ptr == OFF_PWM_C) ? pwm_c :
                   (ptr == OFF_PWM_D) ? pwm_d :
                   (ptr == OFF_FILTER) ? filter_cfg :
                   (ptr == OFF_STATUS) ? status :
                   (ptr == OFF_COUNT_HI) ? filt_count[15:8] :
                   (ptr == OFF_COUNT_LO) ? filt_count[7:0] : 8'h00;

  // save to non-volatile store; the fast sleep rates break the write,
  // so the request is never issued for them and a failure flag is raised
  wire sleep_bad = (sleep_interval == SLEEP_64HZ) || (sleep_interval == SLEEP_512HZ);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      save_busy <= 1'b0;
      save_failed <= 1'b0;
      flash_save_req <= 1'b0;
    end
    else if (ce)
    begin
      flash_save_req <= cmd_save && !sleep_bad;
      if (cmd_save && !sleep_bad)
      begin
        save_busy <= 1'b1;
        save_failed <= 1'b0;
      end
      else if (flash_done)
      begin
        save_busy <= 1'b0;
      end
      if (cmd_save && sleep_bad)
      begin
        save_failed <= 1'b1;
      end
    end
  end

  // sample filters
  wire [1:0] win_sel = filter_cfg[FILT_WIN_LSB +: 2];
  wire avg_en = filter_cfg[FILT_AVG_BIT];
  wire drop_en = filter_cfg[FILT_DROP_BIT];
  wire [4:0] win_len = 5'h02 << win_sel;
  wire traffic = start_det || (state != st_idle);

  logic traffic_seen;
  logic stage;
  logic [SAMPLE_W-1:0] hold;
  logic [MEM_AW-1:0] wr_ptr;
  logic [4:0] fill;
  logic [SUM_W-1:0] sum;
  logic [SAMPLE_W-1:0] old_sample;

  // traffic in the cycle the next scan starts still counts for that scan
  wire next_seen = scan_start ? traffic : (traffic_seen || traffic);
  wire take = sample_valid && !(drop_en && traffic_seen);
  wire [MEM_AW-1:0] old_addr = wr_ptr - win_len[MEM_AW-1:0];
  wire [SUM_W-1:0] drop_term = (fill == win_len) ? SUM_W'(old_sample) : '0;
  wire [SUM_W-1:0] next_sum = sum + SUM_W'(hold) - drop_term;
  // shift amount is widened so the sixteen-sample window does not wrap to a shift of zero
  wire [SUM_W-1:0] avg_val = next_sum >> ({1'b0, win_sel} + 3'h1);

  avg_sample_mem u_mem (
    .clk(clk),
    .ce(ce),
    .wr_en(stage),
    .wr_addr(wr_ptr),
    .wr_data(hold),
    .rd_addr(old_addr),
    .rd_data(old_sample)
  );

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      traffic_seen <= 1'b0;
      stage <= 1'b0;
      hold <= '0;
      wr_ptr <= '0;
      fill <= 5'h00;
      sum <= '0;
      filt_count <= '0;
      filt_valid <= 1'b0;
    end
    else if (ce)
    begin
      traffic_seen <= next_seen;
      stage <= take;
      filt_valid <= stage;
      if (take) hold <= raw_count;
      if (wr_filter)
      begin
        // window change restarts the running sum
        fill <= 5'h00;
        sum <= '0;
      end
      else if (stage)
      begin
        sum <= next_sum;
        wr_ptr <= wr_ptr + 4'h1;
        fill <= (fill == win_len) ? fill : fill + 5'h01;
        filt_count <= avg_en ? avg_val[SAMPLE_W-1:0] : hold;
      end
    end
  end

  // led dimming
  logic [7:0] presc;
  logic [3:0] phase;
  logic trig_d;
  logic single_on;
  logic toggle_on;
  logic delayed_on;
  logic [7:0] delay_cnt;

  wire tick = (presc == pwm_d);
  wire period_end = tick && (phase == 4'hF);
  wire trig_rise = pwm_trigger && !trig_d;
  wire trig_edge = pwm_trigger ^ trig_d;
  // duty 0 is off, 1..15 give fifteen on-times out of sixteen slots
  wire wave = (phase < pwm_a[PWM_DUTY_LSB +: 4]);
  pwm_mode_type mode;
  assign mode = pwm_mode_type'(pwm_b[PWM_MODE_LSB +: 2]);
  wire active = (mode == pwm_normal) ? trig_d :
                (mode == pwm_single) ? single_on :
                (mode == pwm_delayed) ? delayed_on : toggle_on;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      presc <= 8'h00;
      phase <= 4'h0;
      trig_d <= 1'b0;
      single_on <= 1'b0;
      toggle_on <= 1'b0;
      delayed_on <= 1'b0;
      delay_cnt <= 8'h00;
      pwm_out <= 1'b0;
    end
    else if (ce)
    begin
      presc <= tick ? 8'h00 : presc + 8'h01;
      if (tick) phase <= phase + 4'h1;
      trig_d <= pwm_trigger;
      single_on <= trig_rise || (single_on && !period_end);
      if (trig_rise) toggle_on <= ~toggle_on;
      if (trig_edge) delay_cnt <= pwm_c;
      else if (period_end && delay_cnt != 8'h00) delay_cnt <= delay_cnt - 8'h01;
      if (!trig_edge && delay_cnt == 8'h00) delayed_on <= trig_d;
      pwm_out <= active && wave;
    end
  end

endmodule

// [src/button_sense_pkg.sv]
package button_sense_pkg;

  // clock and timing
  localparam int CLK_MHZ = 125;
  localparam int ACK_NORMAL_US = 140;
  localparam int ACK_NORMAL_CYC = ACK_NORMAL_US * CLK_MHZ;
  localparam int ACK_SAVE_US = 100;
  localparam int ACK_SAVE_CYC = ACK_SAVE_US * CLK_MHZ;
  localparam logic [9:0] BOOT_CYCLES = 10'h3FF;

  // register offsets
  localparam logic [7:0] OFF_PWM_A = 8'h18;
  localparam logic [7:0] OFF_PWM_B = 8'h19;
  localparam logic [7:0] OFF_PWM_C = 8'h1A;
  localparam logic [7:0] OFF_PWM_D = 8'h1B;
  localparam logic [7:0] OFF_FILTER = 8'h30;
  localparam logic [7:0] OFF_COMMAND = 8'h31;
  localparam logic [7:0] OFF_STATUS = 8'h32;
  localparam logic [7:0] OFF_COUNT_HI = 8'h33;
  localparam logic [7:0] OFF_COUNT_LO = 8'h34;

  // command codes and reset values
  localparam logic [7:0] CMD_SAVE = 8'h01;
  localparam logic [7:0] PWM_RESET = 8'h00;
  localparam logic [7:0] FILTER_RESET = 8'h00;

  // field positions
  localparam int FILT_WIN_LSB = 0;
  localparam int FILT_AVG_BIT = 2;
  localparam int FILT_DROP_BIT = 3;
  localparam int PWM_DUTY_LSB = 0;
  localparam int PWM_MODE_LSB = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_FAIL_BIT = 1;
  localparam int STAT_BOOT_BIT = 2;

  // sleep interval codes
  localparam logic [1:0] SLEEP_1HZ = 2'h0;
  localparam logic [1:0] SLEEP_8HZ = 2'h1;
  localparam logic [1:0] SLEEP_64HZ = 2'h2;
  localparam logic [1:0] SLEEP_512HZ = 2'h3;

  // sample path
  localparam int SAMPLE_W = 16;
  localparam int MEM_AW = 4;
  localparam int MEM_DEPTH = 16;
  localparam int SUM_W = 20;

  typedef enum logic [2:0] {
    st_idle, st_addr, st_addr_ack, st_rx, st_rx_ack, st_tx, st_tx_ack
  } i2c_state_type;

  typedef enum logic [1:0] {
    pwm_normal, pwm_single, pwm_delayed, pwm_toggle
  } pwm_mode_type;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_type;

endpackage

// [src/avg_sample_mem.sv]
module avg_sample_mem
  import button_sense_pkg::*;
(
  // clock
  input wire logic clk,
  input wire logic ce,
  // write side
  input wire logic wr_en,
  input wire logic [MEM_AW-1:0] wr_addr,
  input wire logic [SAMPLE_W-1:0] wr_data,
  // read side
  input wire logic [MEM_AW-1:0] rd_addr,
  output logic [SAMPLE_W-1:0] rd_data
);

  logic [SAMPLE_W-1:0] mem [MEM_DEPTH];

  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      if (wr_en)
      begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// [bench/button_sense_port_chk.sv]
module button_sense_port_chk
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial port
  input wire logic scl_in,
  input wire logic sda_oe,
  // filter
  input wire logic sample_valid,
  input wire logic filt_valid,
  // store path
  input wire logic [1:0] sleep_interval,
  input wire logic flash_done,
  input wire logic flash_save_req,
  input wire logic save_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic scl_d;
  logic [7:0] since_fall;
  logic [10:0] since_rst;
  // cycles since the last serial clock fall, saturating
  always_ff @(posedge clk)
  begin
    scl_d <= scl_in;
    since_fall <= (rst || (scl_d && !scl_in)) ? 8'h00 : since_fall + {7'h0, since_fall != 8'hFF};
    since_rst <= rst ? 11'h000 : since_rst + {10'h0, since_rst != 11'h7FF};
  end
  sequence s_save_start;
    flash_save_req ##0 save_busy;
  endsequence
  sequence s_save_end;
    flash_done && save_busy && !flash_save_req;
  endsequence
  a_ack_latency: assert property ($rose(sda_oe) |-> since_fall < 8'h07)
    else $error("acknowledge late after clock fall");
  a_ack_low_phase: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in, 2))
    else $error("data line changed outside clock low phase");
  a_boot_quiet: assert property (since_rst < 11'h3E8 |-> !sda_oe)
    else $error("data line driven before boot");
  a_save_allowed: assert property (flash_save_req |-> !sleep_interval[1])
    else $error("store started at a fast sleep rate");
  a_save_start: assert property (flash_save_req |-> save_busy && !$past(save_busy))
    else $error("store request without busy start");
  a_req_single: assert property (s_save_start |=> !flash_save_req)
    else $error("store request longer than one cycle");
  a_busy_holds: assert property (save_busy && !flash_done |=> save_busy)
    else $error("busy dropped before store done");
  a_busy_clear: assert property (s_save_end |=> !save_busy)
    else $error("busy stuck after store done");
  a_no_ack_busy: assert property ($rose(sda_oe) |-> !save_busy)
    else $error("acknowledge while store busy");
  a_filt_timing: assert property (filt_valid |-> $past(sample_valid, 2))
    else $error("filter output without sample");
endmodule

// [bench/i2c_host_model.sv]
module i2c_host_model #(
  parameter logic [6:0] DEV = 7'h37
)
(
  // clock
  input wire logic clk,
  // bus
  input wire logic sda_oe,
  output logic scl,
  output logic sda,
  // read result
  output logic rx_new,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pull = 1'h0;
  // open drain with pull-up: a released line reads high
  assign sda = !(pull || sda_oe);
  initial
  begin
    scl = 1'h1;
    rx_new = 1'h0;
    rx_byte = 8'h00;
  end
  task automatic half();
    repeat (6) @(negedge clk);
  endtask
  task automatic start();
    half();
    pull = 1'h0;
    half();
    scl = 1'h1;
    half();
    pull = 1'h1;
    half();
    scl = 1'h0;
  endtask
  task automatic stop();
    half();
    pull = 1'h1;
    half();
    scl = 1'h1;
    half();
    pull = 1'h0;
  endtask
  // data moves mid low phase, away from both clock edges
  task automatic bit_io(input logic b, output logic seen);
    half();
    pull = !b;
    half();
    scl = 1'h1;
    half();
    seen = sda;
    scl = 1'h0;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(mack, s);
    ack = !s;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic k1, k2, k3;
    start();
    xfer({DEV, 1'h0}, 1'h1, r, k1);
    xfer(a, 1'h1, r, k2);
    xfer(d, 1'h1, r, k3);
    stop();
    ok = k1 && k2 && k3;
  endtask
  task automatic rd(input logic [7:0] a, output logic ok);
    logic [7:0] r;
    logic k1, k2, k3, k4;
    start();
    xfer({DEV, 1'h0}, 1'h1, r, k1);
    xfer(a, 1'h1, r, k2);
    start();
    xfer({DEV, 1'h1}, 1'h1, r, k3);
    xfer(8'hFF, 1'h1, r, k4);
    stop();
    ok = k1 && k2 && k3;
    rx_byte = r;
    rx_new = 1'h1;
    @(negedge clk);
    rx_new = 1'h0;
  endtask
endmodule

// [bench/button_sense_host_port_fixes_bench.sv]
bind button_sense_port button_sense_port_chk chk (
  .clk(clk), .rst(rst), .scl_in(scl_in), .sda_oe(sda_oe), .sample_valid(sample_valid),
  .filt_valid(filt_valid), .sleep_interval(sleep_interval), .flash_done(flash_done),
  .flash_save_req(flash_save_req), .save_busy(save_busy)
);
module button_sense_host_port_fixes_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import button_sense_pkg::*;
  localparam logic [6:0] DEV = 7'h37;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic scl, sda, sda_out, sda_oe, rx_new, filt_valid, pwm_out;
  logic flash_save_req, save_busy, save_failed;
  logic scan_start = 1'h0;
  logic sample_valid = 1'h0;
  logic pwm_trigger = 1'h0;
  logic flash_done = 1'h0;
  logic [1:0] sleep_interval = SLEEP_1HZ;
  logic [15:0] raw_count = 16'h0000;
  logic [15:0] filt_count;
  logic [7:0] rx_byte;
  logic [31:0] seed = 32'hC864A26B;
  logic [15:0] exp_rd[$];
  logic [15:0] exp_filt[$];
  int bad_count = 0;
  int n_tests = 0;
  always #4 clk = !clk;
  button_sense_port #(.DEV_ADDR(DEV)) uut (
    .clk(clk), .rst(rst), .ce(1'h1), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .scan_start(scan_start), .sample_valid(sample_valid),
    .raw_count(raw_count), .filt_count(filt_count), .filt_valid(filt_valid),
    .pwm_trigger(pwm_trigger), .pwm_out(pwm_out), .sleep_interval(sleep_interval),
    .flash_done(flash_done), .flash_save_req(flash_save_req), .save_busy(save_busy),
    .save_failed(save_failed)
  );
  i2c_host_model #(.DEV(DEV)) host (
    .clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda), .rx_new(rx_new), .rx_byte(rx_byte)
  );
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_tests++;
    if (seen !== want)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic stop_test();
    if (bad_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host.wr(a, d, ok);
    check({15'h0, ok}, 16'h0001);
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    exp_rd.push_back({8'h00, d});
    host.rd(a, ok);
    check({15'h0, ok}, 16'h0001);
  endtask
  task automatic sample(input logic [15:0] v);
    raw_count = v;
    sample_valid = 1'h1;
    @(negedge clk);
    sample_valid = 1'h0;
    repeat (3) @(negedge clk);
  endtask
  task automatic scan();
    scan_start = 1'h1;
    @(negedge clk);
    scan_start = 1'h0;
    @(negedge clk);
  endtask
  task automatic trig();
    pwm_trigger = 1'h1;
    repeat (2) @(negedge clk);
    pwm_trigger = 1'h0;
    repeat (2) @(negedge clk);
  endtask
  task automatic count(input int m, output int c);
    c = 0;
    repeat (m) @(negedge clk) c += int'(pwm_out);
  endtask
  always @(posedge clk)
  begin
    if (rx_new)
      check({8'h00, rx_byte}, exp_rd.size() > 0 ? exp_rd.pop_front() : 16'hDEAD);
    if (filt_valid && exp_filt.size() == 0)
      check(16'h0001, 16'h0000);
    else if (filt_valid)
      check(filt_count, exp_filt.pop_front());
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    bad_count++;
    stop_test();
  end
  initial
  begin
    logic ok;
    logic [15:0] s;
    logic [19:0] sum;
    logic [15:0] win[$];
    int a;
    int b;
    repeat (16) @(negedge clk);
    rst = 1'h0;
    // wait out the boot delay, the port ignores the bus until booted is set
    repeat (1100) @(negedge clk);
    reg_rd(OFF_STATUS, 8'h04);
    for (int i = 0; i < 4; i++)
    begin
      s = 16'(rnd());
      reg_wr(OFF_PWM_A + 8'(i), s[7:0]);
      reg_rd(OFF_PWM_A + 8'(i), s[7:0]);
    end
    reg_rd(8'h20, 8'h00);
    // fast rates first: the store must refuse, then succeed at 8 Hz and 1 Hz
    for (int i = 0; i < 4; i++)
    begin
      sleep_interval = 2'(3 - i);
      reg_wr(OFF_COMMAND, CMD_SAVE);
      if (i < 2)
      begin
        reg_rd(OFF_STATUS, 8'h06);
        check({15'h0, save_failed}, 16'h0001);
      end
      else
      begin
        check({15'h0, save_busy}, 16'h0001);
        host.wr(OFF_PWM_A, 8'h00, ok);
        check({15'h0, ok}, 16'h0000);
        flash_done = 1'h1;
        @(negedge clk);
        flash_done = 1'h0;
        @(negedge clk);
        check({15'h0, save_busy}, 16'h0000);
        reg_rd(OFF_STATUS, 8'h04);
      end
    end
    sleep_interval = SLEEP_512HZ;
    reg_wr(OFF_PWM_B, 8'h00);
    reg_wr(OFF_PWM_D, 8'h00);
    // a short delay count keeps a stale long count out of the delayed-mode test
    reg_wr(OFF_PWM_C, 8'h02);
    pwm_trigger = 1'h1;
    for (int n = 0; n < 16; n++)
    begin
      reg_wr(OFF_PWM_A, 8'(n));
      repeat (4) @(negedge clk);
      count(64, a);
      check(16'(a), 16'(4 * n));
    end
    pwm_trigger = 1'h0;
    reg_wr(OFF_PWM_B, 8'h03);
    trig();
    count(64, a);
    trig();
    count(64, b);
    check({15'h0, (a == 60 && b == 0) || (a == 0 && b == 60)}, 16'h0001);
    reg_wr(OFF_PWM_B, 8'h01);
    trig();
    count(64, a);
    check({15'h0, a <= 15}, 16'h0001);
    reg_wr(OFF_PWM_B, 8'h02);
    pwm_trigger = 1'h1;
    count(16, a);
    repeat (32) @(negedge clk);
    count(64, b);
    check({15'h0, a == 0 && b == 60}, 16'h0001);
    for (int w = 0; w < 4; w++)
    begin
      reg_wr(OFF_FILTER, 8'(4 + w));
      sum = 20'h00000;
      win.delete();
      // two samples past a full window make the oldest one drop out of the sum
      for (int k = 0; k < (2 << w) + 2; k++)
      begin
        s = 16'(rnd());
        sum += {4'h0, s};
        win.push_back(s);
        if (win.size() > (2 << w))
          sum -= {4'h0, win.pop_front()};
        exp_filt.push_back(16'(sum >> (w + 1)));
        sample(s);
      end
    end
    reg_wr(OFF_FILTER, 8'h08);
    // let the stop reach the port so the write does not count against the next scan
    repeat (8) @(negedge clk);
    scan();
    s = 16'(rnd());
    exp_filt.push_back(s);
    sample(s);
    scan();
    reg_rd(OFF_COUNT_HI, s[15:8]);
    reg_rd(OFF_COUNT_LO, s[7:0]);
    sample(16'(rnd()));
    repeat (8) @(negedge clk);
    check(16'(exp_rd.size() + exp_filt.size()), 16'h0000);
    stop_test();
  end
endmodule
